// File: inc/lpdl_defs.vh
// Purpose: shared constants for the memory data-lane pin block
// Assumes: 250 MHz system clock
// Notes:   lane, width and timing figures only
`ifndef LPDL_DEFS_VH
`define LPDL_DEFS_VH
`define LPDL_CA_W        10
`define LPDL_DQ_W_NARROW 16
`define LPDL_DQ_W_WIDE   32
`define LPDL_LANE_W      8
`define LPDL_SYS_CLK_MHZ 250
`define LPDL_MEM_AW      4
`define LPDL_RD_RESP_CYC 2
`endif

// File: verilog/lpdl_sync2.v
// Purpose: two-flop synchroniser for a bus of levels
// Assumes: destination clock is the system clock
// Notes:   first stage is read only by the second
`timescale 1ns/100ps
`default_nettype none
module lpdl_sync2 #(
  parameter W = 1
) (
  // Clock and reset
  input  wire         i_sys_clk,
  input  wire         i_sys_rst,
  // Data
  input  wire [W-1:0] i_async,
  output reg  [W-1:0] o_sync
);
  reg [W-1:0] meta;
  always @(posedge i_sys_clk)
  begin
    if (i_sys_rst)
    begin
      meta   <= {W{1'b0}};
      o_sync <= {W{1'b0}};
    end
    else
    begin
      meta   <= i_async;
      o_sync <= meta;
    end
  end
endmodule
`default_nettype wire

// File: verilog/lpdl_lane_mem.v
// Purpose: byte-lane storage with per-lane write masking
// Assumes: one beat written per call, index addressed
// Notes:   masked lanes keep their old contents
`timescale 1ns/100ps
`default_nettype none
module lpdl_lane_mem #(
  parameter LANES = 2,
  parameter AW    = 4
) (
  // Clock and reset
  input  wire                  i_sys_clk,
  input  wire                  i_sys_rst,
  // Write port
  input  wire                  i_wr,
  input  wire [AW-1:0]         i_waddr,
  input  wire [LANES*8-1:0]    i_wdata,
  input  wire [LANES-1:0]      i_wmask,
  // Read port
  input  wire [AW-1:0]         i_raddr,
  output wire [LANES*8-1:0]    o_rdata
);
  genvar g;
  generate
    for (g = 0; g < LANES; g = g + 1)
    begin : g_lane
      // One byte column per lane, so each column has a single writer
      reg [7:0] col [0:(1<<AW)-1];
      integer   k;
      assign o_rdata[g*8 +: 8] = col[i_raddr];
      always @(posedge i_sys_clk)
      begin
        if (i_sys_rst)
        begin
          for (k = 0; k < (1<<AW); k = k + 1)
            col[k] <= 8'h00;
        end
        else if (i_wr && !i_wmask[g])
          col[i_waddr] <= i_wdata[g*8 +: 8];
      end
    end
  endgenerate
endmodule
`default_nettype wire

// File: verilog/lpdl_pins.v
// Purpose: device-side pin logic of a DDR memory data lane
// Assumes: link clock and strobes oversampled by the 250 MHz system clock
// Notes:   command decode is simplified to read/write with a word address
`timescale 1ns/100ps
`default_nettype none
`include "lpdl_defs.vh"
module lpdl_pins #(
  parameter WIDE = 0,
  parameter AW   = `LPDL_MEM_AW
) (
  // Clock and reset
  input  wire                       i_sys_clk,
  input  wire                       i_sys_rst,
  // Command side from the controller
  input  wire                       i_ck,
  input  wire                       i_cke,
  input  wire                       i_cs_n,
  input  wire [`LPDL_CA_W-1:0]      i_ca,
  // Data lanes
  input  wire [`LPDL_DQ_W_WIDE-1:0] i_dq,
  output reg  [`LPDL_DQ_W_WIDE-1:0] o_dq,
  output reg  [3:0]                 o_dq_oe_n,
  input  wire [3:0]                 i_dqs_t,
  output reg  [3:0]                 o_dqs_t,
  output reg  [3:0]                 o_dqs_c,
  output reg  [3:0]                 o_dqs_oe_n,
  input  wire [3:0]                 i_dm,
  // Test
  input  wire                       i_boundary_scan_enable,
  output reg                        o_scan_active,
  output reg                        o_write_seen
);
  // ************************************************
  // Geometry
  // ************************************************
  // width by configuration
  localparam DQW   = WIDE ? `LPDL_DQ_W_WIDE : `LPDL_DQ_W_NARROW;
  localparam LANES = DQW / `LPDL_LANE_W;
  localparam ST_IDLE = 2'd0;
  localparam ST_WR   = 2'd1;
  localparam ST_RD   = 2'd2;
  // Lanes beyond the configured width stay released
  localparam [3:0] LANE_OE_N = WIDE ? 4'h0 : 4'hc;

  // ************************************************
  // Input synchronisers
  // ************************************************
  wire [3:0]                 s_ctl;
  wire [`LPDL_CA_W-1:0]      s_ca;
  wire [`LPDL_DQ_W_WIDE-1:0] s_dq;
  wire [3:0]                 s_dqs;
  wire [3:0]                 s_dm;
  lpdl_sync2 #(.W(4)) u_sctl (
    .i_sys_clk (i_sys_clk),
    .i_sys_rst (i_sys_rst),
    .i_async   ({i_boundary_scan_enable, i_cs_n, i_cke, i_ck}),
    .o_sync    (s_ctl)
  );
  // Data and strobe share one chain so their relative timing is kept
  lpdl_sync2 #(.W(`LPDL_CA_W + `LPDL_DQ_W_WIDE + 8)) u_sdat (
    .i_sys_clk (i_sys_clk),
    .i_sys_rst (i_sys_rst),
    .i_async   ({i_ca, i_dq, i_dqs_t, i_dm}),
    .o_sync    ({s_ca, s_dq, s_dqs, s_dm})
  );
  wire s_ck   = s_ctl[0];
  wire s_cke  = s_ctl[1];
  wire s_cs_n = s_ctl[2];
  wire s_sen  = s_ctl[3];

  reg                  ck_d;
  reg [3:0]            dqs_d;
  reg                  cke_r;
  reg [1:0]            state;
  reg [`LPDL_CA_W-1:0] ca_rise;
  reg                  cmd_pend;
  reg                  cmd_cs;
  reg [AW-1:0]         addr;
  reg [1:0]            beat_cnt;
  reg [2:0]            rd_cnt;
  reg                  mem_wr;
  reg [DQW-1:0]        mem_wdata;
  reg [LANES-1:0]      mem_wmask;
  wire [DQW-1:0]       mem_rdata;

  wire ck_rise = s_ck & ~ck_d;
  wire ck_fall = ~s_ck & ck_d;

  // ************************************************
  // Write lane capture
  // ************************************************
  // Each lane holds its byte and mask until every lane has seen
  // its own strobe edge; skew between lanes is absorbed here
  wire [LANES-1:0] lane_edge;
  wire [LANES-1:0] lane_got;
  wire [DQW-1:0]   lane_data;
  wire [LANES-1:0] lane_mask;
  wire             in_wr     = (state == ST_WR);
  wire             beat_take = in_wr & (&lane_got);
  genvar g;
  generate
    for (g = 0; g < LANES; g = g + 1)
    begin : g_wlane
      reg       got;
      reg [7:0] data;
      reg       mask;
      assign lane_edge[g]        = s_dqs[g] ^ dqs_d[g];
      assign lane_got[g]         = got;
      assign lane_data[g*8 +: 8] = data;
      assign lane_mask[g]        = mask;
      always @(posedge i_sys_clk)
      begin
        if (i_sys_rst)
        begin
          got  <= 1'b0;
          data <= 8'h00;
          mask <= 1'b0;
        end
        // Own strobe toggles during reads and must not count
        else if (!in_wr)
          got <= 1'b0;
        else if (lane_edge[g] && (!got || beat_take))
        begin
          got  <= 1'b1;
          data <= s_dq[g*8 +: 8];
          mask <= s_dm[g];
        end
        else if (beat_take)
          got <= 1'b0;
      end
    end
  endgenerate

  // ************************************************
  // Command capture
  // ************************************************
  always @(posedge i_sys_clk)
  begin
    if (i_sys_rst)
    begin
      ck_d     <= 1'b0;
      dqs_d    <= 4'h0;
      cke_r    <= 1'b0;
      ca_rise  <= {`LPDL_CA_W{1'b0}};
      cmd_pend <= 1'b0;
      cmd_cs   <= 1'b0;
    end
    else
    begin
      ck_d     <= s_ck;
      dqs_d    <= s_dqs;
      cmd_pend <= 1'b0;
      if (ck_rise)
      begin
        cke_r   <= s_cke;
        cmd_cs  <= s_cke & ~s_cs_n;
        ca_rise <= s_ca;
      end
      // Falling CA half carries no field in this decode
      // falling edge completes a selected command as cmd_pend
      if (ck_fall && cmd_cs && cke_r)
        cmd_pend <= 1'b1;
    end
  end

  // ************************************************
  // Transfer sequencer
  // ************************************************
  always @(posedge i_sys_clk)
  begin
    if (i_sys_rst)
    begin
      state      <= ST_IDLE;
      addr       <= {AW{1'b0}};
      beat_cnt   <= 2'd0;
      rd_cnt     <= 3'd0;
      mem_wr     <= 1'b0;
      mem_wdata  <= {DQW{1'b0}};
      mem_wmask  <= {LANES{1'b0}};
      o_dq       <= {`LPDL_DQ_W_WIDE{1'b0}};
      o_dq_oe_n  <= 4'hf;
      o_dqs_t    <= 4'h0;
      o_dqs_c    <= 4'hf;
      o_dqs_oe_n <= 4'hf;
      o_write_seen <= 1'b0;
    end
    else
    begin
      mem_wr <= 1'b0;
      case (state)
        ST_IDLE:
        begin
          o_dq_oe_n  <= 4'hf;
          o_dqs_oe_n <= 4'hf;
          beat_cnt   <= 2'd0;
          if (cmd_pend && cke_r)
          begin
            addr <= ca_rise[AW+1:2];
            if (ca_rise[0])
              state <= ST_WR;
            else if (ca_rise[1])
            begin
              state  <= ST_RD;
              rd_cnt <= 3'd0;
            end
          end
        end
        ST_WR:
        begin
          if (beat_take)
          begin
            mem_wdata <= lane_data;
            mem_wmask <= lane_mask;
            mem_wr    <= 1'b1;
            o_write_seen <= 1'b1;
            addr      <= addr + 1'b1;
            beat_cnt  <= beat_cnt + 2'd1;
            if (beat_cnt == 2'd3)
              state <= ST_IDLE;
          end
          // abort drops the rest of the burst
          if (!cke_r)
            state <= ST_IDLE;
        end
        ST_RD:
        begin
          if (!cke_r)
            state <= ST_IDLE;
          else if (rd_cnt < `LPDL_RD_RESP_CYC)
            rd_cnt <= rd_cnt + 3'd1;
          else
          begin
            rd_cnt <= 3'd0;
            o_dq_oe_n     <= LANE_OE_N;
            o_dqs_oe_n    <= LANE_OE_N;
            o_dq[DQW-1:0] <= mem_rdata;
            o_dqs_t       <= ~o_dqs_t;
            o_dqs_c       <= ~o_dqs_c;
            addr          <= addr + 1'b1;
            beat_cnt      <= beat_cnt + 2'd1;
            if (beat_cnt == 2'd3)
              state <= ST_IDLE;
          end
        end
        default:
          state <= ST_IDLE;
      endcase
    end
  end

  // ************************************************
  // Storage
  // ************************************************
  lpdl_lane_mem #(.LANES(LANES), .AW(AW)) u_mem (
    .i_sys_clk (i_sys_clk),
    .i_sys_rst (i_sys_rst),
    .i_wr      (mem_wr),
    .i_waddr   (addr - 1'b1),
    .i_wdata   (mem_wdata),
    .i_wmask   (mem_wmask),
    .i_raddr   (addr),
    .o_rdata   (mem_rdata)
  );

  // ************************************************
  // Scan
  // ************************************************
  // Test pin is slow, so the synchroniser latency costs nothing
  always @(posedge i_sys_clk)
  begin
    if (i_sys_rst)
      o_scan_active <= 1'b0;
    else
      o_scan_active <= s_sen;
  end
endmodule
`default_nettype wire

// File: verification/lpdl_ctrl_model.sv
// Purpose: controller model for the lane pins
// Assumes: link clock runs only in frames
// Notes:   released lines show inverted value
`timescale 1ns/100ps
`default_nettype none
module lpdl_ctrl_model (
  // Pins
  output logic        o_ck,
  output logic        o_cs_n,
  output logic [9:0]  o_ca,
  output logic [31:0] o_dq,
  output logic [3:0]  o_dqs_t,
  output logic [3:0]  o_dm
);
  initial
  begin
    o_ck = 1'b0;
    o_cs_n = 1'b1;
    o_ca = 10'h0;
    o_dq = 32'h0;
    o_dqs_t = 4'h0;
    o_dm = 4'h0;
  end
  // command held across both link edges
  task automatic cmd(input logic [9:0] c, input logic sel_n);
  begin
    o_ca = c;
    o_cs_n = sel_n;
    #31.25 o_ck = 1'b1;
    #62.5 o_ck = 1'b0;
    #31.25 o_ca = ~c;
    o_cs_n = 1'b1;
  end
  endtask
  task automatic wr(input logic [31:0] d, input logic [3:0] m);
  begin
    o_dq = d;
    o_dm = m;
    #31.25 o_dqs_t = ~o_dqs_t;
    // Released half way to the next beat, never in the step of the next one
    #15.6 o_dq = ~d;
    o_dm = ~m;
    #15.6;
  end
  endtask
endmodule
`default_nettype wire

// File: verification/lpdl_pins_props.sv
// Purpose: port checks of the lane pins
// Assumes: bound to every instance
// Notes:   scan latency at most four cycles
`timescale 1ns/100ps
`default_nettype none
module lpdl_pins_props #(
  parameter WIDE = 0
) (
  // Watched ports
  input wire logic        i_sys_clk,
  input wire logic        i_sys_rst,
  input wire logic        i_boundary_scan_enable,
  input wire logic [31:0] o_dq,
  input wire logic [3:0]  o_dq_oe_n,
  input wire logic [3:0]  o_dqs_t,
  input wire logic [3:0]  o_dqs_c,
  input wire logic [3:0]  o_dqs_oe_n,
  input wire logic        o_scan_active,
  input wire logic        o_write_seen
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_sys_rst);
  sequence s_scan_low;
    !i_boundary_scan_enable [*4];
  endsequence
  sequence s_scan_high;
    i_boundary_scan_enable [*4];
  endsequence
  a_reset_idle: assert property (disable iff (1'b0)
    i_sys_rst |=> o_dq_oe_n == 4'hf && o_dqs_t == 4'h0) else $error("lines driven in reset");
  a_strobe_diff: assert property (o_dqs_c == ~o_dqs_t)
    else $error("strobe pair not complementary");
  a_strobe_dir: assert property (o_dqs_oe_n == o_dq_oe_n)
    else $error("strobe direction differs from data");
  a_edge_align: assert property ($changed(o_dq) |-> $changed(o_dqs_t) || $changed(o_dq_oe_n))
    else $error("read data moved off strobe edge");
  a_lane_group: assert property (o_dq_oe_n[1] == o_dq_oe_n[0] &&
    o_dq_oe_n[3:2] == (WIDE == 0 ? 2'b11 : {2{o_dq_oe_n[0]}})) else $error("lane drive mismatch");
  a_scan_on: assert property ($rose(i_boundary_scan_enable) |-> ##[1:4] o_scan_active)
    else $error("scan not enabled");
  a_scan_off: assert property (s_scan_low |=> !o_scan_active)
    else $error("scan active while disabled");
  a_scan_hold: assert property (s_scan_high |=> o_scan_active)
    else $error("scan dropped while enabled");
  a_write_quiet: assert property ($rose(o_write_seen) |-> o_dq_oe_n == 4'hf)
    else $error("memory drove lines during write");
endmodule
bind lpdl_pins lpdl_pins_props #(.WIDE(WIDE)) u_props (.i_sys_clk, .i_sys_rst,
  .i_boundary_scan_enable, .o_dq, .o_dq_oe_n, .o_dqs_t, .o_dqs_c, .o_dqs_oe_n,
  .o_scan_active, .o_write_seen);
`default_nettype wire

// File: verification/tb_top.sv
// Purpose: testbench of the lane pins
// Assumes: wide build, four lanes
// Notes:   expected memory kept here
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cke = 1'b1;
  logic boundary_scan_enable = 1'b0;
  int num_errors = 0;
  int compares = 0;
  int cyc = 0;
  logic [31:0] mem [16];
  wire ck, cs_n, act, seen;
  wire [9:0] ca;
  wire [31:0] mdq, rdq, dqw, lm;
  wire [3:0] mdqs, rdqs, rdqs_c, dm, oe, soe, dqsw;
  assign lm = {{8{oe[3]}}, {8{oe[2]}}, {8{oe[1]}}, {8{oe[0]}}};
  assign dqw = (mdq & lm) | (rdq & ~lm);
  assign dqsw = (mdqs & soe) | (rdqs & ~soe);
  always #2 clk = ~clk;
  lpdl_ctrl_model u_ctrl (.o_ck(ck), .o_cs_n(cs_n), .o_ca(ca), .o_dq(mdq),
    .o_dqs_t(mdqs), .o_dm(dm));
  lpdl_pins #(.WIDE(1)) dut (.i_sys_clk(clk), .i_sys_rst(rst), .i_ck(ck),
    .i_cke(cke), .i_cs_n(cs_n), .i_ca(ca), .i_dq(dqw), .o_dq(rdq), .o_dq_oe_n(oe),
    .i_dqs_t(dqsw), .o_dqs_t(rdqs), .o_dqs_c(rdqs_c), .o_dqs_oe_n(soe), .i_dm(dm),
    .i_boundary_scan_enable(boundary_scan_enable), .o_scan_active(act), .o_write_seen(seen));
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
  begin
    compares++;
    if (got !== exp)
    begin
      num_errors++;
      $display("unexpected %s exp %h got %h", nm, exp, got);
    end
  end
  endtask
  task automatic test_done();
  begin
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  end
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      num_errors++;
      test_done();
    end
  end
  task automatic t_write(input logic [3:0] a, input logic [31:0] d, input logic [15:0] m);
    logic [31:0] v;
  begin
    #1;
    u_ctrl.cmd({4'h0, a, 2'b01}, 1'b0);
    for (int i = 0; i < 4; i++)
    begin
      v = d ^ (i * 32'h01010101);
      u_ctrl.wr(v, m[4*i+:4]);
      for (int j = 0; j < 4; j++)
        if (!m[4*i+j])
          mem[a+i][8*j+:8] = v[8*j+:8];
    end
    repeat (8) @(posedge clk);
    chk("write seen", seen, 1);
  end
  endtask
  task automatic t_read(input logic [3:0] a);
    logic [3:0] p;
  begin
    #1;
    fork
      u_ctrl.cmd({4'h0, a, 2'b10}, 1'b0);
      for (int i = 0; i < 4; i++)
      begin
        p = rdqs;
        for (int n = 0; n < 200 && rdqs === p; n++)
          @(negedge clk);
        chk("read beat", rdq, mem[a+i]);
        chk("read drive", oe, 0);
      end
    join
    repeat (40) @(posedge clk);
    chk("released", oe, 4'hf);
  end
  endtask
  task automatic t_ignored(input logic sel_n, input logic en);
    logic drove;
  begin
    drove = 1'b0;
    #1 cke = en;
    fork
      u_ctrl.cmd(10'h016, sel_n);
      repeat (70) @(negedge clk)
        drove = drove | (oe != 4'hf);
    join
    chk("no answer", drove, 0);
    @(posedge clk);
    #1 cke = 1'b1;
  end
  endtask
  task automatic t_scan(input logic v);
  begin
    @(posedge clk);
    #1 boundary_scan_enable = v;
    repeat (6) @(posedge clk);
    chk("scan", act, v);
  end
  endtask
  // ********
  // Sequence
  // ********
  initial
  begin
    repeat (8) @(posedge clk);
    #1 rst = 1'b0;
    repeat (4) @(posedge clk);
    chk("reset oe", {soe, oe, 3'h0, seen, 3'h0, act}, 16'hff00);
    t_write(4'h5, 32'h11223344, 16'h0);
    t_read(4'h5);
    t_write(4'h5, 32'ha5c3e10f, 16'h8421);
    t_read(4'h5);
    t_ignored(1'b1, 1'b1);
    t_ignored(1'b0, 1'b0);
    t_scan(1'b1);
    t_scan(1'b0);
    test_done();
  end
endmodule
`default_nettype wire
